// file: qos_sched_wred_buffer_mgr.sv
// Purpose: Egress scheduler, random early drop and buffer region accounting.
// Assumes: One gigabit egress port of eight queues; frame engine on the same clock.
// Notes: Decisions and grants are registered; region use counters are in buffer slots.
//
// Local design decisions: the placing of the registers and the strobed register port.
module qos_sched_wred_buffer_mgr (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic rx_arrive_in,
	input wire logic cls_valid_in,
	input wire logic [2:0] cls_class_in,
	input wire logic cls_high_drop_in,
	input wire logic [4:0] cls_src_port_in,
	input wire logic [13:0] cls_bytes_in,
	input wire logic rel_valid_in,
	input wire logic [3:0] rel_region_in,
	input wire logic [4:0] rel_src_port_in,
	input wire logic tx_ready_in,
	input wire logic tx_done_in,
	input wire logic [13:0] tx_done_bytes_in,
	output logic temp_full_out,
	output logic dec_valid_out,
	output logic dec_drop_out,
	output logic [3:0] dec_region_out,
	output logic tx_grant_out,
	output logic [2:0] tx_queue_out
);
	logic [7:0] gig_port_a_sched_config_r;
	logic [63:0] weight_r;
	logic [16:0] shaper_r;
	logic [6:0] drop_rate_ctrl_a_r;
	logic [14:0] drop_rate_ctrl_b_r;
	logic [23:0] q_thresh_r;
	logic [31:0] cres_lo_r;
	logic [23:0] cres_hi_r;
	logic [15:0] port_res_r;
	logic [31:0] rd_mux;
	logic [19:0] q_bytes_r [qos_pkg::NUM_Q];
	logic [7:0] q_frames_r [qos_pkg::NUM_Q];
	logic [11:0] q_age_r [qos_pkg::NUM_Q];
	logic signed [23:0] q_credit_r [qos_pkg::NUM_Q];
	logic [7:0] cls_used_r [qos_pkg::NUM_Q];
	logic [7:0] port_used_r [qos_pkg::NUM_PORTS];
	logic [7:0] shared_used_r, temp_used_r, temp_nxt;
	logic [6:0] tick_cnt_r;
	logic tick_r, busy_r, shp_ok;
	logic [15:0] lfsr_r;
	qos_pkg::sched_mode_t mode;
	logic sp, dbm, shp_en, sel_v, reload, any_wfq;
	logic [2:0] sel_q;
	logic [7:0] ne;
	logic signed [12:0] best, sl;
	logic [24:0] n_bytes;
	logic [15:0] n_kb;
	logic [1:0] level;
	logic [9:0] q_kb;
	logic over_thr, hit_hi, hit_lo, wred_drop, exempt, drop_c, acc;
	logic c_room, sh_room, p_room;
	logic [3:0] region_c;

	// Byte field q of a packed group of byte-wide fields.
	function automatic logic [7:0] fld8(input logic [63:0] v, input int q);
		return v[q * 8 +: 8];
	endfunction

	// Up/down slot counter step.
	function automatic logic [7:0] upd8(input logic [7:0] c, input logic inc, input logic dec);
		return c + {7'h00, inc} - {7'h00, dec};
	endfunction

	// True with probability pct percent for a uniform random byte.
	function automatic logic pct_hit(input logic [6:0] pct, input logic [7:0] r);
		return 16'(r) * 16'(qos_pkg::PCT_FULL) < 16'(pct) * 16'(qos_pkg::PCT_SCALE);
	endfunction

	// Delay bound of queue q in microseconds.
	function automatic logic [11:0] bound_us(input int q);
		case (q)
			7, 6: return qos_pkg::DB_P76_US;
			5: return qos_pkg::DB_P5_US;
			4: return qos_pkg::DB_P4_US;
			3: return qos_pkg::DB_P3_US;
			default: return qos_pkg::DB_P2_US;
		endcase
	endfunction

	// Register writes; software sets mode, weights, shaper, drop and buffer sizes.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			gig_port_a_sched_config_r <= 8'h00;
			weight_r <= qos_pkg::RST_WEIGHTS;
			shaper_r <= 17'h0_0000;
			drop_rate_ctrl_a_r <= 7'h00;
			drop_rate_ctrl_b_r <= 15'h0000;
			q_thresh_r <= 24'h00_0000;
			cres_lo_r <= qos_pkg::RST_CRES_LO;
			cres_hi_r <= qos_pkg::RST_CRES_HI;
			port_res_r <= qos_pkg::RST_PRES;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				qos_pkg::A_SCHED: gig_port_a_sched_config_r <= reg_wdata_in[7:0];
				qos_pkg::A_WGT_LO: weight_r[31:0] <= reg_wdata_in;
				qos_pkg::A_WGT_HI: weight_r[63:32] <= reg_wdata_in;
				qos_pkg::A_SHAPER: shaper_r <= reg_wdata_in[16:0];
				qos_pkg::A_DROP_A: drop_rate_ctrl_a_r <= reg_wdata_in[6:0];
				qos_pkg::A_DROP_B: drop_rate_ctrl_b_r <= reg_wdata_in[14:0];
				qos_pkg::A_THRESH: q_thresh_r <= reg_wdata_in[23:0];
				qos_pkg::A_CRES_LO: cres_lo_r <= reg_wdata_in;
				qos_pkg::A_CRES_HI: cres_hi_r <= reg_wdata_in[23:0];
				qos_pkg::A_PRES: port_res_r <= reg_wdata_in[15:0];
				default: ;
			endcase
		end
	end

	// Read mux; status shows weight check, temp and shared use, and drop level.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_addr_in)
			qos_pkg::A_SCHED: rd_mux = {24'h00_0000, gig_port_a_sched_config_r};
			qos_pkg::A_WGT_LO: rd_mux = weight_r[31:0];
			qos_pkg::A_WGT_HI: rd_mux = weight_r[63:32];
			qos_pkg::A_SHAPER: rd_mux = {15'h0000, shaper_r};
			qos_pkg::A_DROP_A: rd_mux = {25'h000_0000, drop_rate_ctrl_a_r};
			qos_pkg::A_DROP_B: rd_mux = {17'h0_0000, drop_rate_ctrl_b_r};
			qos_pkg::A_THRESH: rd_mux = {8'h00, q_thresh_r};
			qos_pkg::A_CRES_LO: rd_mux = cres_lo_r;
			qos_pkg::A_CRES_HI: rd_mux = {8'h00, cres_hi_r};
			qos_pkg::A_PRES: rd_mux = {16'h0000, port_res_r};
			qos_pkg::A_STATUS: rd_mux = {7'h00, 11'(fld8(weight_r, 0)) + 11'(fld8(weight_r, 1))
				+ 11'(fld8(weight_r, 2)) + 11'(fld8(weight_r, 3)) + 11'(fld8(weight_r, 4))
				+ 11'(fld8(weight_r, 5)) + 11'(fld8(weight_r, 6)) + 11'(fld8(weight_r, 7))
				== 11'(qos_pkg::WEIGHT_TOTAL), temp_used_r, shared_used_r, 6'h00, level};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is valid only in the cycle after the strobe.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
		end
	end

	// Microsecond tick for ages and shaper refill, plus the random source.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tick_cnt_r <= 7'h00;
			tick_r <= 1'b0;
			lfsr_r <= qos_pkg::LFSR_SEED;
		end else begin
			// Wrap on the same compare as the tick, so one tick comes every TICK_CYCLES cycles.
			tick_r <= tick_cnt_r == 7'(qos_pkg::TICK_CYCLES - 1);
			tick_cnt_r <= (tick_cnt_r == 7'(qos_pkg::TICK_CYCLES - 1)) ? 7'h00 : tick_cnt_r + 7'h01;
			lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? qos_pkg::LFSR_TAPS : 16'h0000);
		end
	end

	// shaping honoured only in SP configurations
	always_comb begin
		mode = qos_pkg::sched_mode_t'(gig_port_a_sched_config_r[qos_pkg::MODE_MSB:qos_pkg::MODE_LSB]);
		sp = mode == qos_pkg::OP_SP_DB || mode == qos_pkg::OP_SP_WFQ;
		dbm = mode == qos_pkg::OP_DB || mode == qos_pkg::OP_SP_DB;
		shp_en = shaper_r[qos_pkg::SHAPE_EN_BIT] && sp;
		for (int q = 0; q < qos_pkg::NUM_Q; q++) begin
			ne[q] = q_frames_r[q] != 8'h00;
		end
	end

	qos_shaper u_shaper (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.tick_in(tick_r),
		.en_in(shp_en),
		.peak_in(shaper_r[6:0]),
		.avg_in(shaper_r[14:8]),
		.sent_in(tx_done_in && tx_queue_out == 3'h6),
		.bytes_in(tx_done_bytes_in),
		.ok_out(shp_ok)
	);

	// Queue selection. Delay-bound queues go by least slack to their bound.
	always_comb begin
		sel_v = 1'b0;
		sel_q = 3'h0;
		reload = 1'b0;
		any_wfq = 1'b0;
		best = 13'sh0FFF;
		sl = 13'sh0000;
		if (sp && ne[7]) begin
			sel_v = 1'b1;
			sel_q = 3'h7;
		end else if (sp && ne[6] && shp_ok) begin
			sel_v = 1'b1;
			sel_q = 3'h6;
		end else if (dbm) begin
			for (int q = qos_pkg::FIRST_RES_CLASS; q < qos_pkg::NUM_Q; q++) begin
				sl = $signed({1'b0, bound_us(q)}) - $signed({1'b0, q_age_r[q]});
				if (ne[q] && (mode == qos_pkg::OP_DB || q < 6) && sl <= best) begin
					best = sl;
					sel_v = 1'b1;
					sel_q = 3'(q);
				end
			end
			// best effort only when all else idle or P6 held by the shaper
			if (!sel_v && (ne[1] || ne[0])) begin
				sel_v = 1'b1;
				sel_q = ne[1] ? 3'h1 : 3'h0;
			end
		end else begin
			for (int q = 0; q < qos_pkg::NUM_Q; q++) begin
				if (ne[q] && (mode == qos_pkg::OP_WFQ || q < 6)) begin
					any_wfq = 1'b1;
					if (q_credit_r[q] > 24'sh00_0000) begin
						sel_v = 1'b1;
						sel_q = 3'(q);
					end
				end
			end
			reload = any_wfq && !sel_v;
		end
	end

	// One grant per transmission; the next waits for the done report.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tx_grant_out <= 1'b0;
			tx_queue_out <= 3'h0;
			busy_r <= 1'b0;
		end else begin
			tx_grant_out <= !busy_r && tx_ready_in && sel_v;
			if (!busy_r && tx_ready_in && sel_v) begin
				tx_queue_out <= sel_q;
				busy_r <= 1'b1;
			end else if (tx_done_in) begin
				busy_r <= 1'b0;
			end
		end
	end

	always_comb begin
		n_bytes = dbm ? 25'(q_bytes_r[3]) * 25'(qos_pkg::N_MUL_P3) + 25'(q_bytes_r[2])
			* 25'(qos_pkg::N_MUL_P2) + 25'(q_bytes_r[1])
			: 25'(q_bytes_r[3]) + 25'(q_bytes_r[2]) + 25'(q_bytes_r[1]);
		n_kb = 16'(n_bytes >> qos_pkg::KB_SHIFT);
		level = n_kb >= qos_pkg::LVL3_KB ? 2'h3 : n_kb >= qos_pkg::LVL2_KB ? 2'h2
			: n_kb >= qos_pkg::LVL1_KB ? 2'h1 : 2'h0;
	end

	// Drop and region decision for the classified frame.
	always_comb begin
		q_kb = q_bytes_r[cls_class_in][19:10];
		over_thr = cls_class_in >= 3'h3 ? q_kb >= 10'(q_thresh_r[7:0])
			: cls_class_in == 3'h2 ? q_kb >= 10'(q_thresh_r[15:8]) : q_kb >= 10'(q_thresh_r[23:16]);
		hit_hi = pct_hit(drop_rate_ctrl_a_r, lfsr_r[7:0]);
		hit_lo = 1'b0;
		if (level == 2'h2 && over_thr) begin
			hit_hi = pct_hit(drop_rate_ctrl_b_r[6:0], lfsr_r[7:0]);
			hit_lo = pct_hit(drop_rate_ctrl_b_r[14:8], lfsr_r[15:8]);
		end
		if (level == 2'h3 && over_thr) begin
			hit_hi = 1'b1;
			hit_lo = 1'b1;
		end
		wred_drop = level != 2'h0 && (cls_high_drop_in ? hit_hi : hit_lo);
		exempt = mode == qos_pkg::OP_WFQ ? 1'b0 : cls_class_in <= 3'h1 || (sp && cls_class_in >= 3'h6);
		c_room = cls_class_in >= 3'(qos_pkg::FIRST_RES_CLASS)
			&& cls_used_r[cls_class_in] < (cls_class_in >= 3'h6
			? cres_hi_r[8 * (cls_class_in - 3'h6) +: 8] : cres_lo_r[8 * (cls_class_in - 3'h2) +: 8]);
		sh_room = shared_used_r < cres_hi_r[23:16];
		p_room = port_used_r[cls_src_port_in] < (cls_src_port_in >= 5'(qos_pkg::NUM_FAST)
			? port_res_r[15:8] : port_res_r[7:0]);
		region_c = c_room ? {1'b0, cls_class_in} : sh_room ? qos_pkg::RGN_SHARED
			: p_room ? qos_pkg::RGN_PORT : qos_pkg::RGN_NONE;
		drop_c = (wred_drop && !exempt) || region_c == qos_pkg::RGN_NONE;
		acc = cls_valid_in && !drop_c;
		// arrivals wait in the temporary region
		temp_nxt = upd8(temp_used_r, rx_arrive_in, cls_valid_in);
	end

	// Decision outputs and temporary region fill.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			dec_valid_out <= 1'b0;
			dec_drop_out <= 1'b0;
			dec_region_out <= qos_pkg::RGN_NONE;
			temp_used_r <= 8'h00;
			temp_full_out <= 1'b0;
		end else begin
			dec_valid_out <= cls_valid_in;
			dec_drop_out <= cls_valid_in && drop_c;
			dec_region_out <= acc ? region_c : qos_pkg::RGN_NONE;
			temp_used_r <= temp_nxt;
			temp_full_out <= temp_nxt >= qos_pkg::TEMP_SLOTS;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			shared_used_r <= 8'h00;
			for (int i = 0; i < qos_pkg::NUM_Q; i++) begin
				cls_used_r[i] <= 8'h00;
			end
			for (int i = 0; i < qos_pkg::NUM_PORTS; i++) begin
				port_used_r[i] <= 8'h00;
			end
		end else begin
			shared_used_r <= upd8(shared_used_r, acc && region_c == qos_pkg::RGN_SHARED,
				rel_valid_in && rel_region_in == qos_pkg::RGN_SHARED);
			for (int i = 0; i < qos_pkg::NUM_Q; i++) begin
				cls_used_r[i] <= upd8(cls_used_r[i], acc && region_c == 4'(i),
					rel_valid_in && rel_region_in == 4'(i));
			end
			for (int i = 0; i < qos_pkg::NUM_PORTS; i++) begin
				port_used_r[i] <= upd8(port_used_r[i],
					acc && region_c == qos_pkg::RGN_PORT && cls_src_port_in == 5'(i),
					rel_valid_in && rel_region_in == qos_pkg::RGN_PORT && rel_src_port_in == 5'(i));
			end
		end
	end

	// Queue bytes, frames, head ages and fair-queuing credit. Age restarts when the head leaves.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			for (int q = 0; q < qos_pkg::NUM_Q; q++) begin
				q_bytes_r[q] <= 20'h0_0000;
				q_frames_r[q] <= 8'h00;
				q_age_r[q] <= 12'h000;
				q_credit_r[q] <= 24'sh00_0000;
			end
		end else begin
			for (int q = 0; q < qos_pkg::NUM_Q; q++) begin
				q_bytes_r[q] <= q_bytes_r[q] + ((acc && cls_class_in == 3'(q)) ? 20'(cls_bytes_in) : 20'h0_0000)
					- ((tx_done_in && tx_queue_out == 3'(q)) ? 20'(tx_done_bytes_in) : 20'h0_0000);
				q_frames_r[q] <= upd8(q_frames_r[q], acc && cls_class_in == 3'(q),
					tx_done_in && tx_queue_out == 3'(q));
				if (!ne[q] || (tx_done_in && tx_queue_out == 3'(q))) begin
					q_age_r[q] <= 12'h000;
				end else if (tick_r && q_age_r[q] != qos_pkg::AGE_MAX) begin
					q_age_r[q] <= q_age_r[q] + 12'h001;
				end
				if (!ne[q]) begin
					q_credit_r[q] <= 24'sh00_0000;
				end else begin
					q_credit_r[q] <= q_credit_r[q]
						+ (reload ? 24'(fld8(weight_r, q)) * 24'(qos_pkg::WFQ_QUANTUM) : 24'sh00_0000)
						- ((tx_done_in && tx_queue_out == 3'(q)) ? 24'(tx_done_bytes_in) : 24'sh00_0000);
				end
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	property p_sp_first;
		!busy_r && tx_ready_in && sp && ne[7] |=> tx_grant_out && tx_queue_out == 3'h7;
	endproperty
	a_sp_first: assert property (p_sp_first) else $error("SP queue not served first");

	property p_be_last;
		tx_grant_out && dbm && tx_queue_out <= 3'h1 |-> $past(ne[7:2]) == 6'h00;
	endproperty
	a_be_last: assert property (p_be_last) else $error("BE granted while others wait");

	property p_exempt;
		cls_valid_in && exempt && region_c != qos_pkg::RGN_NONE |=> !dec_drop_out;
	endproperty
	a_exempt: assert property (p_exempt) else $error("Exempt queue dropped");

	property p_shaper;
		tx_grant_out && tx_queue_out == 3'h6 |-> $past(shp_ok);
	endproperty
	a_shaper: assert property (p_shaper) else $error("Shaped class sent without credit");

	property p_lvl1;
		cls_valid_in && level == 2'h1 && !cls_high_drop_in && region_c != qos_pkg::RGN_NONE |=> !dec_drop_out;
	endproperty
	a_lvl1: assert property (p_lvl1) else $error("Low-drop frame dropped at level 1");

	property p_lvl3;
		cls_valid_in && level == 2'h3 && over_thr && !exempt |=> dec_drop_out;
	endproperty
	a_lvl3: assert property (p_lvl3) else $error("Level 3 frame not dropped");

	property p_temp;
		cls_valid_in && !rx_arrive_in |=> temp_used_r == $past(temp_used_r) - 8'h01;
	endproperty
	a_temp: assert property (p_temp) else $error("Temporary region not released");

	property p_region;
		cls_valid_in && c_room && !drop_c |=> dec_region_out == {1'b0, $past(cls_class_in)};
	endproperty
	a_region: assert property (p_region) else $error("Class region not used first");

	property p_release;
		rel_valid_in && rel_region_in == qos_pkg::RGN_SHARED && !(acc && region_c == qos_pkg::RGN_SHARED)
			|=> shared_used_r == $past(shared_used_r) - 8'h01;
	endproperty
	a_release: assert property (p_release) else $error("Shared slot not returned");

	c_shaped: cover property (tx_grant_out && tx_queue_out == 3'h6);
	c_lvl3_drop: cover property (dec_drop_out && level == 2'h3);
	c_port_rgn: cover property (dec_region_out == qos_pkg::RGN_PORT);
	c_reload: cover property (reload);
endmodule // qos_sched_wred_buffer_mgr

// file: qos_pkg.sv
// Purpose: Shared constants and types of the egress QoS, drop and buffer block.
// Assumes: One 100 MHz system clock; queue index equals frame class.
// Notes: Summary of the block's behaviour follows.
// Summary of operation
// - Nonempty strict-priority queue is always served first, unless P6 is held by its shaper.
// - Best-effort queues served only when others idle or P6 shaper-held, under delay bound.
// - SP and BE queues dropped only on shortage, except BE in WFQ-only mode.
// - Eight class weights sum to 64.
// - In WFQ-only mode low queues face random drop too.
// - Shaping only for gigabit class P6.
// - Peak rate below peak setting over 64.
// - Average rate at most average setting over 64.
// - Shaper may hold frames while line idles.
// - Drop level from N at 120/140/160 KB.
// - N weighted 16/4/1 under delay bound.
// - Level 1 drops high-drop by percentage only.
// - Level 2 drops above per-queue byte threshold.
// - Level 3 drops every non-exempt frame above queue threshold.
// - Arrivals held in temporary region before dropping.
// - Reserved regions exist for classes 2 to 7.
// - Buffer region follows class among eight.
// - Per-source-port regions sized by port type.
// - Allocate class, then shared, then port region.
// - Delay-bound choice follows ages and occupancy.
package qos_pkg;
	typedef enum logic [1:0] {OP_DB, OP_SP_DB, OP_SP_WFQ, OP_WFQ} sched_mode_t;
	localparam int CLK_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int LINE_MBPS = 1000;
	localparam int BYTES_PER_US = LINE_MBPS / 8;
	localparam int RATE_DEN = 64;
	localparam int MAX_FRAME = 1522;
	localparam int WFQ_QUANTUM = 64;
	localparam int N_MUL_P3 = 16;
	localparam int N_MUL_P2 = 4;
	localparam int PCT_SCALE = 256;
	localparam int PCT_FULL = 100;
	localparam int NUM_PORTS = 26;
	localparam int NUM_FAST = 24;
	localparam int NUM_Q = 8;
	localparam int FIRST_RES_CLASS = 2;
	localparam int WEIGHT_TOTAL = 64;
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 6;
	localparam int SHAPE_EN_BIT = 16;
	localparam int KB_SHIFT = 10;
	localparam logic [7:0] TEMP_SLOTS = 8'h20;
	localparam logic [11:0] AGE_MAX = 12'hFFF;
	localparam logic [11:0] DB_P76_US = 12'h0A0;
	localparam logic [11:0] DB_P5_US = 12'h140;
	localparam logic [11:0] DB_P4_US = 12'h280;
	localparam logic [11:0] DB_P3_US = 12'h500;
	localparam logic [11:0] DB_P2_US = 12'hA00;
	localparam logic [15:0] LVL1_KB = 16'h0078;
	localparam logic [15:0] LVL2_KB = 16'h008C;
	localparam logic [15:0] LVL3_KB = 16'h00A0;
	localparam logic [3:0] RGN_SHARED = 4'h8;
	localparam logic [3:0] RGN_PORT = 4'h9;
	localparam logic [3:0] RGN_NONE = 4'hF;
	localparam logic [5:0] A_SCHED = 6'h00;
	localparam logic [5:0] A_WGT_LO = 6'h04;
	localparam logic [5:0] A_WGT_HI = 6'h08;
	localparam logic [5:0] A_SHAPER = 6'h0C;
	localparam logic [5:0] A_DROP_A = 6'h10;
	localparam logic [5:0] A_DROP_B = 6'h14;
	localparam logic [5:0] A_THRESH = 6'h18;
	localparam logic [5:0] A_CRES_LO = 6'h1C;
	localparam logic [5:0] A_CRES_HI = 6'h20;
	localparam logic [5:0] A_PRES = 6'h24;
	localparam logic [5:0] A_STATUS = 6'h28;
	localparam logic [63:0] RST_WEIGHTS = 64'h0808_0808_0808_0808;
	localparam logic [31:0] RST_CRES_LO = 32'h0404_0404;
	localparam logic [23:0] RST_CRES_HI = 24'h40_0404;
	localparam logic [15:0] RST_PRES = 16'h0802;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
endpackage

// file: qos_shaper.sv
// Purpose: Two token buckets limiting peak and average rate of one class.
// Assumes: Credits are kept in 1/64 byte units, refilled once per microsecond.
// Notes: The peak bucket holds no credit, so frames are spaced at the peak rate.
module qos_shaper (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic tick_in,
	input wire logic en_in,
	input wire logic [6:0] peak_in,
	input wire logic [6:0] avg_in,
	input wire logic sent_in,
	input wire logic [13:0] bytes_in,
	output logic ok_out
);
	localparam logic signed [23:0] AVG_CAP = 24'(qos_pkg::MAX_FRAME * qos_pkg::RATE_DEN);
	logic signed [23:0] pk_r, av_r, pk_nxt, av_nxt, cost, pk_add, av_add;

	// A sent frame costs its bytes; each tick refills by setting times line bytes per us.
	always_comb begin
		cost = sent_in ? 24'(bytes_in) * 24'(qos_pkg::RATE_DEN) : 24'h00_0000;
		pk_add = tick_in ? 24'(peak_in) * 24'(qos_pkg::BYTES_PER_US) : 24'h00_0000;
		av_add = tick_in ? 24'(avg_in) * 24'(qos_pkg::BYTES_PER_US) : 24'h00_0000;
		pk_nxt = pk_r - cost + pk_add;
		av_nxt = av_r - cost + av_add;
		if (pk_nxt > 24'sh00_0000) begin
			pk_nxt = 24'sh00_0000;
		end
		if (av_nxt > AVG_CAP) begin
			av_nxt = AVG_CAP;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !en_in) begin
			pk_r <= 24'sh00_0000;
			av_r <= AVG_CAP;
			ok_out <= 1'b1;
		end else begin
			pk_r <= pk_nxt;
			av_r <= av_nxt;
			ok_out <= (pk_nxt >= 24'sh00_0000) && (av_nxt >= 24'sh00_0000);
		end
	end
endmodule // qos_shaper

// file: qos_mac_model.sv
// Purpose: Egress MAC model that answers each transmit grant.
// Assumes: One frame in flight; each frame finishes five cycles after its grant.
// Notes: The length bus shows changing junk outside the done pulse.
module qos_mac_model (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic en_in,
	input wire logic [13:0] len_in,
	input wire logic grant_in,
	output logic ready_out,
	output logic done_out,
	output logic [13:0] len_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_r;
	// The delay stands for line time, so a second grant would show up as an overlap.
	always_ff @(posedge clk_sys_in) begin
		done_out <= 1'b0;
		len_out <= ~len_out;
		if (srst_in) begin
			wait_r <= 3'h0;
			len_out <= 14'h0;
		end else if (grant_in) begin
			wait_r <= 3'h4;
		end else if (wait_r != 3'h0) begin
			wait_r <= wait_r - 3'h1;
			if (wait_r == 3'h1) begin
				done_out <= 1'b1;
				len_out <= len_in;
			end
		end
	end
	// Ready is a plain level chosen by the bench, so it can stall the port.
	assign ready_out = en_in;
endmodule // qos_mac_model

// file: qos_sched_wred_buffer_mgr_test.sv
// Purpose: Self-checking bench for the egress QoS, drop and buffer block.
// Assumes: Reset values of the register map; one gigabit egress port.
// Notes: Each scenario resets the block first, so queues never carry over.
module qos_sched_wred_buffer_mgr_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, wr = 0, rd = 0, rx = 0, cv = 0, hd = 0, rv = 0, en = 0;
	logic rdy, done, grant, tfull, dv, dd;
	logic [5:0] addr = 0;
	logic [31:0] wd = 0, rdata;
	logic [2:0] cls = 0, q;
	logic [4:0] sp = 5'h18, rp = 0;
	logic [13:0] by = 0, dby;
	logic [3:0] rr = 0, rg;
	int mismatches = 0, tests_run = 0;
	qos_sched_wred_buffer_mgr dut (.clk_sys_in(clk), .srst_in(srst), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.rx_arrive_in(rx), .cls_valid_in(cv), .cls_class_in(cls), .cls_high_drop_in(hd),
		.cls_src_port_in(sp), .cls_bytes_in(by), .rel_valid_in(rv), .rel_region_in(rr),
		.rel_src_port_in(rp), .tx_ready_in(rdy), .tx_done_in(done), .tx_done_bytes_in(dby),
		.temp_full_out(tfull), .dec_valid_out(dv), .dec_drop_out(dd), .dec_region_out(rg),
		.tx_grant_out(grant), .tx_queue_out(q));
	qos_mac_model mac (.clk_sys_in(clk), .srst_in(srst), .en_in(en), .len_in(14'h0040),
		.grant_in(grant), .ready_out(rdy), .done_out(done), .len_out(dby));
	// Free-running system clock.
	initial forever #5 clk = ~clk;
	task end_sim;
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task rst;
		@(posedge clk);
		srst <= 1;
		en <= 0;
		repeat (2) @(posedge clk);
		srst <= 0;
	endtask
	task regw(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just then.
	task regr(input logic [5:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	task frm(input logic [2:0] c, input logic [13:0] b, input logic dr, input logic [3:0] r);
		@(posedge clk);
		cls <= c;
		by <= b;
		cv <= 1;
		rx <= 1;
		@(posedge clk);
		cv <= 0;
		rx <= 0;
		#1 chk({dv, dd, r}, {1'b1, dr, rg});
	endtask
	// Bounded wait for the next grant, then compare the queue.
	task gnt(input logic [2:0] e);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (grant !== 1'b1 && i < 50);
		chk({grant, q}, {1'b1, e});
	endtask
	task t_regs;
		rst;
		regr(6'h04, 32'h0808_0808);
		regr(6'h20, 32'h0040_0404);
		regr(6'h24, 32'h0000_0802);
		regw(6'h28, 32'hFFFF_FFFF);
		regr(6'h28, 32'h0100_0000);
		regr(6'h3C, 32'h0000_0000);
	endtask
	task t_alloc;
		rst;
		frm(3'h5, 14'h0040, 0, 4'h5);
		frm(3'h1, 14'h0040, 0, 4'h8);
		repeat (4) frm(3'h2, 14'h0040, 0, 4'h2);
		frm(3'h2, 14'h0040, 0, 4'h8);
		regr(6'h28, 32'h0100_0200);
		@(posedge clk);
		rr <= 4'h8;
		rp <= 5'h18;
		rv <= 1;
		rx <= 1;
		@(posedge clk);
		rv <= 0;
		rx <= 0;
		regr(6'h28, 32'h0101_0100);
		chk({31'h0, tfull}, 32'h0);
	endtask
	task t_sp;
		rst;
		regw(6'h00, 32'h0000_0080);
		frm(3'h3, 14'h0040, 0, 4'h3);
		frm(3'h7, 14'h0040, 0, 4'h7);
		@(posedge clk);
		en <= 1;
		gnt(3'h7);
		gnt(3'h3);
	endtask
	task t_be;
		rst;
		frm(3'h1, 14'h0040, 0, 4'h8);
		frm(3'h4, 14'h0040, 0, 4'h4);
		@(posedge clk);
		en <= 1;
		gnt(3'h4);
		gnt(3'h1);
	endtask
	// Peak and average of 1/64 line rate: after one shaped frame the class waits far beyond the grant window.
	task t_shp;
		rst;
		regw(6'h00, 32'h0000_0080);
		regw(6'h0C, 32'h0001_0101);
		frm(3'h6, 14'h0040, 0, 4'h6);
		frm(3'h6, 14'h0040, 0, 4'h6);
		frm(3'h3, 14'h0040, 0, 4'h3);
		@(posedge clk);
		en <= 1;
		gnt(3'h6);
		gnt(3'h3);
	endtask
	task t_wred;
		int i;
		rst;
		regw(6'h00, 32'h0000_00C0);
		regw(6'h18, 32'h0000_0001);
		regw(6'h10, 32'h0000_0000);
		regw(6'h14, 32'h0000_0000);
		for (i = 0; i < 11; i++) frm(3'h3, 14'h3A98, 0, (i < 4) ? 4'h3 : 4'h8);
		repeat (3) @(posedge clk);
		regr(6'h28, 32'h0100_0703);
		frm(3'h3, 14'h0040, 1, 4'hF);
		regw(6'h00, 32'h0000_0080);
		frm(3'h0, 14'h0040, 0, 4'h8);
	endtask
	// A hang counts as a failure and ends the run in the usual place.
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim;
	end
	initial begin
		repeat (12) @(posedge clk);
		srst <= 0;
		t_regs;
		t_alloc;
		t_sp;
		t_be;
		t_shp;
		t_wred;
		end_sim;
	end
endmodule // qos_sched_wred_buffer_mgr_test
